/* dv/latched_fault_event_status_test.sv */
// self-checking bench for the latched fault and event status block
module latched_fault_event_status_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    reg         clk;
    reg         rst;
    reg  [13:0] cond;
    wire [7:0]  addr, wdata, rdata;
    wire        wr, rd, ack, miss, int_pending;
    reg  [7:0]  q;
    reg         m;
    integer     fail_count;
    integer     comparisons;

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    lfe_host lfe_host_i (.CLK(clk), .REG_RDATA(rdata), .REG_ACK(ack), .REG_MISS(miss),
        .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata));
    lfe_top lfe_top_i (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack), .REG_MISS(miss),
        .CH1_POS_SHORT(cond[13]), .CH1_NEG_SHORT(cond[12]), .CH1_POS_VGND(cond[11]),
        .CH1_NEG_VGND(cond[10]), .CH2_POS_SHORT(cond[9]), .CH2_NEG_SHORT(cond[8]),
        .CH2_POS_VGND(cond[7]), .CH2_NEG_VGND(cond[6]), .REGULATOR_SHORT(cond[5]),
        .HEADSET_INSERT(cond[4]), .HEADSET_REMOVE(cond[3]), .HEADSET_BUTTON(cond[2]),
        .ANALOG_UPPER_CROSS(cond[1]), .ANALOG_LOWER_CROSS(cond[0]), .INT_PENDING(int_pending));

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task check(input [7:0] seen, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task rd_reg(input [7:0] a);
        lfe_host_i.access(1'b0, a, 8'h00, q, m);
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        lfe_host_i.access(1'b1, a, d, q, m);
    endtask
    // one-cycle condition, returns once the pending flag has settled
    task pulse(input integer n);
        begin
            @(negedge clk);
            cond[n] = 1'b1;
            @(negedge clk);
            cond = 14'h0000;
            @(negedge clk);
        end
    endtask
    function [7:0] evb(input integer i);
        evb = (i < 3) ? (8'h08 >> i) : (8'h80 >> (i - 3));
    endfunction

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset;
        integer i;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                rd_reg(i == 0 ? 8'h35 : 8'h37 + i[7:0]);
                check(q, 8'h00);
            end
            rd_reg(8'h32);
            check(q, 8'h00);
            rd_reg(8'h33);
            check(q, 8'h30);
            check({7'h00, int_pending}, 8'h00);
        end
    endtask
    task t_channel;
        integer i;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                pulse(13 - i);
                check({7'h00, int_pending}, 8'h01);
                rd_reg(8'h35);
                check(q, i < 4 ? 8'h20 : 8'h10);
                rd_reg(i < 4 ? 8'h38 : 8'h39);
                check(q, 8'h80 >> (i % 4));
                rd_reg(i < 4 ? 8'h38 : 8'h39);
                check(q, 8'h00);
                rd_reg(8'h35);
                check(q, 8'h00);
            end
        end
    endtask
    task t_regulator;
        begin
            wr_reg(8'h39, 8'h02);
            pulse(5);
            check({7'h00, int_pending}, 8'h00);
            rd_reg(8'h39);
            check(q, 8'h03);
            rd_reg(8'h39);
            check(q, 8'h02);
            wr_reg(8'h39, 8'h00);
            pulse(5);
            check({7'h00, int_pending}, 8'h01);
            rd_reg(8'h39);
            check(q, 8'h01);
            @(negedge clk);
            check({7'h00, int_pending}, 8'h00);
        end
    endtask
    // each event unmasked, then masked: masks gate only the pending flag
    task t_events;
        integer i, p;
        begin
            for (p = 0; p < 2; p = p + 1) begin
                wr_reg(8'h32, p ? 8'h3E : 8'h00);
                wr_reg(8'h33, p ? 8'hC0 : 8'h00);
                rd_reg(8'h33);
                check(q, p ? 8'hF0 : 8'h30);
                for (i = 0; i < 5; i = i + 1) begin
                    pulse(4 - i);
                    check({7'h00, int_pending}, p ? 8'h00 : 8'h01);
                    rd_reg(i < 3 ? 8'h3A : 8'h3B);
                    check(q, evb(i));
                    rd_reg(i < 3 ? 8'h3A : 8'h3B);
                    check(q, 8'h00);
                end
                // channel short and driver ground faults under the same masks
                for (i = 0; i < 2; i = i + 1) begin
                    pulse(13 - 2 * i);
                    check({7'h00, int_pending}, p ? 8'h00 : 8'h01);
                    rd_reg(8'h38);
                    check(q, 8'h80 >> (2 * i));
                end
            end
        end
    endtask
    // unmapped read, held condition, ignored write, reset in mid-run
    task t_misc;
        begin
            rd_reg(8'h3C);
            check({q[6:0], m}, 8'h01);
            @(negedge clk);
            cond[4] = 1'b1;
            rd_reg(8'h3A);
            rd_reg(8'h3A);
            check(q, 8'h08);
            @(negedge clk);
            cond[4] = 1'b0;
            rd_reg(8'h3A);
            check(q, 8'h08);
            pulse(4);
            wr_reg(8'h3A, 8'h00);
            rd_reg(8'h3A);
            check(q, 8'h08);
            pulse(13);
            @(negedge clk);
            rst = 1'b1;
            repeat (2) @(negedge clk);
            rst = 1'b0;
            t_reset;
        end
    endtask

    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // main sequence
    initial begin
        rst         = 1'b1;
        cond        = 14'h0000;
        fail_count  = 0;
        comparisons = 0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_channel;
        t_regulator;
        t_events;
        t_misc;
        tally_and_finish;
    end
    // watchdog well beyond the expected run
    initial begin
        #20000;
        fail_count = fail_count + 1;
        tally_and_finish;
    end
endmodule // latched_fault_event_status_test

/* dv/lfe_host.sv */
// host model driving the register strobe port
module lfe_host (
    input  wire       CLK,
    input  wire [7:0] REG_RDATA,
    input  wire       REG_ACK,
    input  wire       REG_MISS,
    output reg  [7:0] REG_ADDR,
    output reg        REG_WR,
    output reg        REG_RD,
    output reg  [7:0] REG_WDATA
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        REG_ADDR  = 8'hFF;
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_WDATA = 8'hFF;
    end

    // reserved bits always carry their reset value
    function [7:0] legal(input [7:0] a, input [7:0] d);
        case (a)
            8'h32:   legal = d & 8'h3E;
            8'h33:   legal = {d[7:6], 6'h30};
            8'h39:   legal = d & 8'h02;
            default: legal = 8'h00;
        endcase
    endfunction

    // one strobe pulse, answer taken mid-cycle while the acknowledge stands
    task access(input wr, input [7:0] a, input [7:0] d, output [7:0] q, output m);
        begin
            @(negedge CLK);
            REG_ADDR  = a;
            REG_WDATA = legal(a, d);
            REG_WR    = wr;
            REG_RD    = !wr;
            @(posedge CLK);
            @(negedge CLK);
            q = (REG_ACK === 1'b1) ? REG_RDATA : 8'hXX;
            m = REG_MISS;
            REG_WR    = 1'b0;
            REG_RD    = 1'b0;
            REG_ADDR  = ~a;                      // parked bus shows no stale value
            REG_WDATA = ~REG_WDATA;
            @(posedge CLK);
        end
    endtask
endmodule // lfe_host

/* dv/lfe_props.sv */
// assertions on the read port and latch behaviour of lfe_top
module lfe_props #(
    parameter AW = 8,
    parameter DW = 8
) (
    input wire          CLK,
    input wire          RST,
    input wire [AW-1:0] REG_ADDR,
    input wire          REG_RD,
    input wire [DW-1:0] REG_RDATA,
    input wire          REG_ACK,
    input wire          REG_MISS,
    input wire          INT_PENDING,
    input wire          CH1_POS_SHORT,
    input wire          CH1_NEG_VGND,
    input wire          CH2_POS_SHORT,
    input wire          REGULATOR_SHORT,
    input wire          HEADSET_INSERT,
    input wire          HEADSET_REMOVE,
    input wire          HEADSET_BUTTON,
    input wire          ANALOG_UPPER_CROSS
);
    timeunit 1ns;
    timeprecision 1ps;

    // read strobes per register, headset inputs idle
    wire rd35  = REG_RD && REG_ADDR == 8'h35;
    wire rd38  = REG_RD && REG_ADDR == 8'h38;
    wire rd39  = REG_RD && REG_ADDR == 8'h39;
    wire rd3a  = REG_RD && REG_ADDR == 8'h3A;
    wire rd3b  = REG_RD && REG_ADDR == 8'h3B;
    wire quiet = !HEADSET_INSERT && !HEADSET_REMOVE && !HEADSET_BUTTON;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_sum_ch1: assert property (CH1_NEG_VGND ##1 !rd38 [*2] ##1 rd35 |=> REG_RDATA[5])
        else $error("summary bit 5 missing");
    chk_sum_ch2: assert property (CH2_POS_SHORT ##1 !rd39 [*2] ##1 rd35 |=> REG_RDATA[4])
        else $error("summary bit 4 missing");
    chk_sum_reserved: assert property (rd35 |=> REG_RDATA[7:6] == 2'h0 && REG_RDATA[3:0] == 4'h0)
        else $error("summary reserved bits set");
    chk_ch1_short: assert property (CH1_POS_SHORT ##1 !rd38 [*4] ##1 rd38 |=> REG_RDATA[7])
        else $error("channel 1 short not latched");
    chk_reg_short: assert property (REGULATOR_SHORT ##1 !rd39 [*2] ##1 rd39 |=> REG_RDATA[0] && !REG_RDATA[3])
        else $error("regulator short not latched");
    chk_insert_latch: assert property (HEADSET_INSERT ##1 !rd3a [*2] ##1 rd3a |=> REG_RDATA[3])
        else $error("insertion not latched");
    chk_hs_reserved: assert property (rd3a |=> REG_RDATA[7:4] == 4'h0 && !REG_RDATA[0])
        else $error("headset reserved bits set");
    chk_upper_cross: assert property (ANALOG_UPPER_CROSS ##1 !rd3b [*2] ##1 rd3b |=> REG_RDATA[7])
        else $error("upper crossing not latched");
    chk_headset_clear: assert property (rd3a && quiet ##1 quiet ##1 rd3a |=> REG_RDATA[3:1] == 3'h0)
        else $error("headset bits not cleared by read");
    chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");

    cover property (rd3a ##1 REG_RDATA[3]);
    cover property (INT_PENDING);
    cover property (REG_ACK && REG_MISS);
endmodule // lfe_props

bind lfe_top lfe_props #(.AW(AW), .DW(DW)) lfe_props_i (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_MISS(REG_MISS),
    .INT_PENDING(INT_PENDING), .CH1_POS_SHORT(CH1_POS_SHORT), .CH1_NEG_VGND(CH1_NEG_VGND),
    .CH2_POS_SHORT(CH2_POS_SHORT), .REGULATOR_SHORT(REGULATOR_SHORT), .HEADSET_INSERT(HEADSET_INSERT),
    .HEADSET_REMOVE(HEADSET_REMOVE), .HEADSET_BUTTON(HEADSET_BUTTON), .ANALOG_UPPER_CROSS(ANALOG_UPPER_CROSS));

/* rtl/lfe_defines.vh */
// register map, field positions and reset values of the latched fault block
`ifndef LFE_DEFINES_VH
`define LFE_DEFINES_VH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define LFE_ADDR_EVT_MASK      8'h32
`define LFE_ADDR_THR_MASK      8'h33
`define LFE_ADDR_SUMMARY       8'h35
`define LFE_ADDR_CH1_FAULT     8'h38
`define LFE_ADDR_CH2_FAULT     8'h39
`define LFE_ADDR_HEADSET       8'h3A
`define LFE_ADDR_THRESHOLD     8'h3B

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define LFE_RST_ZERO           8'h00
`define LFE_RST_EVT_MASK       8'h00
`define LFE_RST_THR_MASK       8'h30
`define LFE_RST_CH1_SPARE      2'h0
`define LFE_RST_REG_MASK       1'h0

// ------------------------------------------------------------------
// channel fault registers: short, virtual ground, spare and regulator bits
// ------------------------------------------------------------------
`define LFE_CH_FAULT_HI        7
`define LFE_CH_FAULT_LO        4
`define LFE_CH1_SPARE_HI       3
`define LFE_CH1_SPARE_LO       2
`define LFE_CH2_REG_MASK_BIT   1
`define LFE_CH2_REG_SHORT_BIT  0

// ------------------------------------------------------------------
// summary, headset and threshold fields
// ------------------------------------------------------------------
`define LFE_SUM_CH1_BIT        5
`define LFE_SUM_CH2_BIT        4
`define LFE_HS_HI              3
`define LFE_HS_LO              1
`define LFE_THR_HI             7
`define LFE_THR_LO             6

// ------------------------------------------------------------------
// event mask fields
// ------------------------------------------------------------------
`define LFE_EMSK_SHORT_BIT     5
`define LFE_EMSK_VGND_BIT      4
`define LFE_EMSK_HS_HI         3
`define LFE_EMSK_HS_LO         1

`endif

/* rtl/lfe_latch.v */
// sticky latch vector: set by a condition, cleared by a report strobe
module lfe_latch #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] cond,
    input  wire         clr,
    output wire [W-1:0] q
);

    // ------------------------------------------------------------------
    // latch state
    // ------------------------------------------------------------------
    reg  [W-1:0] q_r;
    wire [W-1:0] q_nxt;

    // clear by report, but a present condition sets again (set wins)
    assign q_nxt = (q_r & ~{W{clr}}) | cond;

    // state flops, zero at reset
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r <= {W{1'b0}};
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule // lfe_latch

/* rtl/lfe_top.v */
// latched output fault and event status registers with masks
`include "lfe_defines.vh"

module lfe_top #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          CLK,
    input  wire          RST,
    input  wire [AW-1:0] REG_ADDR,
    input  wire          REG_WR,
    input  wire          REG_RD,
    input  wire [DW-1:0] REG_WDATA,
    output wire [DW-1:0] REG_RDATA,
    output wire          REG_ACK,
    output wire          REG_MISS,
    input  wire          CH1_POS_SHORT,
    input  wire          CH1_NEG_SHORT,
    input  wire          CH1_POS_VGND,
    input  wire          CH1_NEG_VGND,
    input  wire          CH2_POS_SHORT,
    input  wire          CH2_NEG_SHORT,
    input  wire          CH2_POS_VGND,
    input  wire          CH2_NEG_VGND,
    input  wire          REGULATOR_SHORT,
    input  wire          HEADSET_INSERT,
    input  wire          HEADSET_REMOVE,
    input  wire          HEADSET_BUTTON,
    input  wire          ANALOG_UPPER_CROSS,
    input  wire          ANALOG_LOWER_CROSS,
    output wire          INT_PENDING
);

    // ------------------------------------------------------------------
    // address decode helper
    // ------------------------------------------------------------------
    function hit;
        input [AW-1:0] addr;
        input [AW-1:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    wire       sel_evt_mask;
    wire       sel_thr_mask;
    wire       sel_summary;
    wire       sel_ch1;
    wire       sel_ch2;
    wire       sel_headset;
    wire       sel_threshold;
    wire       sel_any;
    wire       access;

    wire       rd_ch1;
    wire       rd_ch2;
    wire       rd_headset;
    wire       rd_threshold;

    wire [3:0] ch1_cond;
    wire [3:0] ch2_cond;
    wire [2:0] hs_cond;
    wire [1:0] thr_cond;

    wire [3:0] ch1_q;
    wire [3:0] ch2_q;
    wire       reg_short_q;
    wire [2:0] hs_q;
    wire [1:0] thr_q;

    wire       ch1_any;
    wire       ch2_any;

    reg  [7:0] evt_mask_r;
    reg  [7:0] evt_mask_nxt;
    reg  [7:0] thr_mask_r;
    reg  [7:0] thr_mask_nxt;
    reg  [1:0] ch1_spare_r;
    reg  [1:0] ch1_spare_nxt;
    reg        reg_mask_r;
    reg        reg_mask_nxt;

    reg  [7:0] rdata_r;
    reg  [7:0] rdata_nxt;
    reg        ack_r;
    reg        miss_r;
    reg        miss_nxt;
    reg        int_r;
    reg        int_nxt;

    reg  [7:0] summary_val;
    reg  [7:0] ch1_val;
    reg  [7:0] ch2_val;
    reg  [7:0] hs_val;
    reg  [7:0] thr_val;

    // ------------------------------------------------------------------
    // register select
    // ------------------------------------------------------------------
    assign sel_evt_mask  = hit(REG_ADDR, `LFE_ADDR_EVT_MASK);
    assign sel_thr_mask  = hit(REG_ADDR, `LFE_ADDR_THR_MASK);
    assign sel_summary   = hit(REG_ADDR, `LFE_ADDR_SUMMARY);
    assign sel_ch1       = hit(REG_ADDR, `LFE_ADDR_CH1_FAULT);
    assign sel_ch2       = hit(REG_ADDR, `LFE_ADDR_CH2_FAULT);
    assign sel_headset   = hit(REG_ADDR, `LFE_ADDR_HEADSET);
    assign sel_threshold = hit(REG_ADDR, `LFE_ADDR_THRESHOLD);

    assign sel_any = sel_evt_mask | sel_thr_mask | sel_summary | sel_ch1
                   | sel_ch2 | sel_headset | sel_threshold;
    assign access  = REG_WR | REG_RD;

    // report strobes: a read of a latched register clears it
    assign rd_ch1       = REG_RD & sel_ch1;
    assign rd_ch2       = REG_RD & sel_ch2;
    assign rd_headset   = REG_RD & sel_headset;
    assign rd_threshold = REG_RD & sel_threshold;

    // ------------------------------------------------------------------
    // fault and event conditions, ordered as the field bits
    // ------------------------------------------------------------------
    // channel 1: positive short, negative short, two driver faults
    assign ch1_cond = {CH1_POS_SHORT, CH1_NEG_SHORT,
                       CH1_POS_VGND, CH1_NEG_VGND};
    // channel 2: same layout
    assign ch2_cond = {CH2_POS_SHORT, CH2_NEG_SHORT,
                       CH2_POS_VGND, CH2_NEG_VGND};
    // headset: insert, remove, button
    assign hs_cond  = {HEADSET_INSERT,
                       HEADSET_REMOVE,
                       HEADSET_BUTTON};
    // analog input: upper, lower crossing
    assign thr_cond = {ANALOG_UPPER_CROSS,
                       ANALOG_LOWER_CROSS};

    // ------------------------------------------------------------------
    // sticky latches
    // ------------------------------------------------------------------
    // channel 1 output faults
    lfe_latch #(.W(4)) u_ch1 (
        .clk  (CLK),
        .rst  (RST),
        .cond (ch1_cond),
        .clr  (rd_ch1),
        .q    (ch1_q)
    );

    // channel 2 output faults
    lfe_latch #(.W(4)) u_ch2 (
        .clk  (CLK),
        .rst  (RST),
        .cond (ch2_cond),
        .clr  (rd_ch2),
        .q    (ch2_q)
    );

    // regulator short, reported with channel 2
    lfe_latch #(.W(1)) u_reg (
        .clk  (CLK),
        .rst  (RST),
        .cond (REGULATOR_SHORT),
        .clr  (rd_ch2),
        .q    (reg_short_q)
    );

    // headset events
    lfe_latch #(.W(3)) u_hs (
        .clk  (CLK),
        .rst  (RST),
        .cond (hs_cond),
        .clr  (rd_headset),
        .q    (hs_q)
    );

    // analog threshold events
    lfe_latch #(.W(2)) u_thr (
        .clk  (CLK),
        .rst  (RST),
        .cond (thr_cond),
        .clr  (rd_threshold),
        .q    (thr_q)
    );

    // ------------------------------------------------------------------
    // channel summary
    // ------------------------------------------------------------------
    // any latched short or driver fault of the channel
    assign ch1_any = |ch1_q;
    assign ch2_any = |ch2_q;

    // ------------------------------------------------------------------
    // writable fields
    // ------------------------------------------------------------------
    // next values of masks and spare bits on a write
    always @* begin
        evt_mask_nxt  = evt_mask_r;
        thr_mask_nxt  = thr_mask_r;
        ch1_spare_nxt = ch1_spare_r;
        reg_mask_nxt  = reg_mask_r;
        if (REG_WR) begin
            if (sel_evt_mask) begin
                evt_mask_nxt = REG_WDATA;
            end
            if (sel_thr_mask) begin
                thr_mask_nxt = REG_WDATA;
            end
            if (sel_ch1) begin
                // spare bits are stored as written
                ch1_spare_nxt = REG_WDATA[`LFE_CH1_SPARE_HI:`LFE_CH1_SPARE_LO];
            end
            if (sel_ch2) begin
                reg_mask_nxt = REG_WDATA[`LFE_CH2_REG_MASK_BIT];
            end
        end
    end

    // mask and spare flops
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            evt_mask_r  <= `LFE_RST_EVT_MASK;
            thr_mask_r  <= `LFE_RST_THR_MASK;
            ch1_spare_r <= `LFE_RST_CH1_SPARE;
            reg_mask_r  <= `LFE_RST_REG_MASK;
        end else begin
            evt_mask_r  <= evt_mask_nxt;
            thr_mask_r  <= thr_mask_nxt;
            ch1_spare_r <= ch1_spare_nxt;
            reg_mask_r  <= reg_mask_nxt;
        end
    end

    // ------------------------------------------------------------------
    // read values, reserved bits as zero
    // ------------------------------------------------------------------
    always @* begin
        summary_val = `LFE_RST_ZERO;
        summary_val[`LFE_SUM_CH1_BIT] = ch1_any;
        summary_val[`LFE_SUM_CH2_BIT] = ch2_any;

        ch1_val = `LFE_RST_ZERO;
        ch1_val[`LFE_CH_FAULT_HI:`LFE_CH_FAULT_LO]   = ch1_q;
        ch1_val[`LFE_CH1_SPARE_HI:`LFE_CH1_SPARE_LO] = ch1_spare_r;

        ch2_val = `LFE_RST_ZERO;
        ch2_val[`LFE_CH_FAULT_HI:`LFE_CH_FAULT_LO] = ch2_q;
        ch2_val[`LFE_CH2_REG_MASK_BIT]  = reg_mask_r;
        ch2_val[`LFE_CH2_REG_SHORT_BIT] = reg_short_q;

        hs_val = `LFE_RST_ZERO;
        hs_val[`LFE_HS_HI:`LFE_HS_LO] = hs_q;

        thr_val = `LFE_RST_ZERO;
        thr_val[`LFE_THR_HI:`LFE_THR_LO] = thr_q;
    end

    // ------------------------------------------------------------------
    // read mux and unmapped flag
    // ------------------------------------------------------------------
    // data is the value before the clear of the same edge
    always @* begin
        rdata_nxt = rdata_r;
        miss_nxt  = 1'b0;
        if (access) begin
            miss_nxt = ~sel_any;
        end
        if (REG_RD) begin
            case (REG_ADDR)
                `LFE_ADDR_EVT_MASK: begin
                    rdata_nxt = evt_mask_r;
                end
                `LFE_ADDR_THR_MASK: begin
                    rdata_nxt = thr_mask_r;
                end
                `LFE_ADDR_SUMMARY: begin
                    rdata_nxt = summary_val;
                end
                `LFE_ADDR_CH1_FAULT: begin
                    rdata_nxt = ch1_val;
                end
                `LFE_ADDR_CH2_FAULT: begin
                    rdata_nxt = ch2_val;
                end
                `LFE_ADDR_HEADSET: begin
                    rdata_nxt = hs_val;
                end
                `LFE_ADDR_THRESHOLD: begin
                    rdata_nxt = thr_val;
                end
                default: begin
                    rdata_nxt = `LFE_RST_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------
    // unmasked latched bits raise the request
    always @* begin
        int_nxt = 1'b0;
        if (!evt_mask_r[`LFE_EMSK_SHORT_BIT]) begin
            int_nxt = int_nxt | ch1_q[3] | ch1_q[2] | ch2_q[3] | ch2_q[2];
        end
        if (!evt_mask_r[`LFE_EMSK_VGND_BIT]) begin
            int_nxt = int_nxt | ch1_q[1] | ch1_q[0] | ch2_q[1] | ch2_q[0];
        end
        // headset events, one mask bit each
        int_nxt = int_nxt | |(hs_q & ~evt_mask_r[`LFE_EMSK_HS_HI:`LFE_EMSK_HS_LO]);
        // analog crossings
        int_nxt = int_nxt | |(thr_q & ~thr_mask_r[`LFE_THR_HI:`LFE_THR_LO]);
        // regulator short
        int_nxt = int_nxt | (reg_short_q & ~reg_mask_r);
    end

    // ------------------------------------------------------------------
    // answer flops
    // ------------------------------------------------------------------
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= `LFE_RST_ZERO;
            ack_r   <= 1'b0;
            miss_r  <= 1'b0;
            int_r   <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            ack_r   <= access;
            miss_r  <= miss_nxt;
            int_r   <= int_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign REG_RDATA   = rdata_r;
    assign REG_ACK     = ack_r;
    assign REG_MISS    = miss_r;
    assign INT_PENDING = int_r;

endmodule // lfe_top
